// ==== vlan_tag_port_processor.v ====
`timescale 1ns/1ps
`include "vlan_consts.vh"

// ==========================================================
// descriptor FIFO
module vlan_desc_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire             clk,
  input  wire             srst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// Notes on behaviour
// [RQ1] per-port BPDU mode needs global transparency on
// [RQ2] peer mode: BPDU goes to local processing
// [RQ3] tunnel mode: BPDU forwarded as traffic
// [RQ4] discard mode: BPDU dropped
// [RQ5] network: untagged BPDU local, tagged forwarded
// [RQ6] tag adds four bytes after source address
// [RQ7] TCI: 3b priority, 1b CFI, 12b VID
// [RQ8] generated tags carry CFI zero
// [RQ9] CFI one never leaves untagged port unchanged
// [RQ10] VID zero: keep priority, use port VID
// [RQ11] VID 4095 reserved, never configurable
// [RQ12] resolve destination first, then strip tag
// [RQ13] resolve destination first, then insert PVID tag
// [RQ14] default VID is 1 after reset
// [RQ15] flood only to members, never ingress port
// [RQ16] fixed registration means permanent membership
// [RQ17] forbidden never member; normal follows dynamic
// [RQ18] tagged member port always sends tagged
// [RQ19] untagged member port sends untagged
// [RQ20] acceptance filter: all, tagged or untagged
// [RQ21] ingress filter drops non-member port frames
// [RQ22] only enabled ports forward; all enabled at reset
// [RQ23] management writes per-port and per-VLAN tables
// [RQ24] no member beyond ingress port: drop
module vlan_tag_port_processor (
  input  wire                CLK_SYS,
  input  wire                SRST,
  input  wire                BPDU_TRANSP_EN,
  input  wire                CFG_WE,
  input  wire [1:0]          CFG_SEL,
  input  wire [`PW-1:0]      CFG_PORT,
  input  wire [`VIDW-1:0]    CFG_VID,
  input  wire [31:0]         CFG_WDATA,
  output reg                 CFG_ERR,
  output reg                 INIT_DONE,
  input  wire                IN_VALID,
  output wire                IN_READY,
  input  wire [`PW-1:0]      IN_PORT,
  input  wire [15:0]         IN_ETYPE,
  input  wire [15:0]         IN_TCI,
  input  wire [10:0]         IN_LEN,
  input  wire                IN_BPDU,
  input  wire [`NPORTS-1:0]  IN_DMASK,
  output wire                OUT_VALID,
  input  wire                OUT_READY,
  output wire [`NPORTS-1:0]  OUT_DMASK,
  output wire [`NPORTS-1:0]  OUT_TAGMASK,
  output wire [15:0]         OUT_TCI,
  output wire [10:0]         OUT_LEN,
  output wire                OUT_LOCAL,
  output reg  [15:0]         DROP_CNT
);
  localparam ST_INIT = 2'b01;
  localparam ST_RUN  = 2'b10;

  // ==========================================================
  // membership decode
  function [`NPORTS-1:0] members;
    input [31:0]         vw;
    input [`NPORTS-1:0]  dyn;
    integer              i;
    begin
      members = {`NPORTS{1'b0}};
      for (i = 0; i < `NPORTS; i = i + 1) begin
        case (vw[2*i +: 2])
          `REG_FIXED:  members[i] = 1'b1;            // [RQ16]
          `REG_FORBID: members[i] = 1'b0;            // [RQ17]
          `REG_NORMAL: members[i] = dyn[i];          // [RQ17]
          default:     members[i] = 1'b0;
        endcase
      end
    end
  endfunction

  // ==========================================================
  // configuration tables
  reg [31:0]        vlan_mem [0:`NVLAN-1];
  reg [`NPORTS-1:0] dyn_mem  [0:`NVLAN-1];
  reg               en_q     [0:`NPORTS-1];
  reg               ifilt_q  [0:`NPORTS-1];
  reg [1:0]         acc_q    [0:`NPORTS-1];
  reg [1:0]         bpdu_q   [0:`NPORTS-1];
  reg [`VIDW-1:0]   pvid_q   [0:`NPORTS-1];
  reg [1:0]         state_q;
  reg [`VIDW-1:0]   init_q;
  integer           p;

  wire              running  = state_q[1];
  wire [`VIDW-1:0]  wpvid    = CFG_WDATA[`PC_PVID_LO +: `VIDW];
  wire              vid_bad  = (CFG_VID == `VID_RSVD) || (CFG_VID == `VID_PRIO);
  wire              pvid_bad = (wpvid == `VID_RSVD) || (wpvid == `VID_PRIO);
  wire              cfg_ok_port = (CFG_SEL == `CFG_SEL_PORT) && !pvid_bad;
  wire              cfg_ok_vlan = (CFG_SEL == `CFG_SEL_VLAN) && !vid_bad;
  wire              cfg_ok_dyn  = (CFG_SEL == `CFG_SEL_DYN) && !vid_bad;
  wire              cfg_take = CFG_WE && running;

  // table writes; the sweep after reset owns the port so X never reaches decode
  always @(posedge CLK_SYS) begin
    if (!running) begin
      vlan_mem[init_q] <= (init_q == `PVID_RST) ? `VW_RST_DEF : `VW_RST_OTHER;
      dyn_mem[init_q]  <= {`NPORTS{1'b0}};
    end else if (cfg_take && cfg_ok_vlan) begin
      vlan_mem[CFG_VID] <= CFG_WDATA;                // [RQ23]
    end else if (cfg_take && cfg_ok_dyn) begin
      dyn_mem[CFG_VID] <= CFG_WDATA[`NPORTS-1:0];    // [RQ17]
    end
  end

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      state_q   <= ST_INIT;
      init_q    <= {`VIDW{1'b0}};
      INIT_DONE <= 1'b0;
      CFG_ERR   <= 1'b0;
      for (p = 0; p < `NPORTS; p = p + 1) begin
        en_q[p]    <= 1'b1;                          // [RQ22]
        ifilt_q[p] <= 1'b0;
        acc_q[p]   <= `ACC_ALL;
        bpdu_q[p]  <= `BPDU_PEER;
        pvid_q[p]  <= `PVID_RST;                     // [RQ14]
      end
    end else begin
      CFG_ERR <= 1'b0;
      case (state_q)
        ST_INIT: begin
          init_q <= init_q + 1'b1;
          if (init_q == `VID_RSVD) begin
            state_q   <= ST_RUN;
            INIT_DONE <= 1'b1;
          end
        end
        ST_RUN: begin
          if (CFG_WE) begin
            // reserved and priority VIDs are refused outright
            CFG_ERR <= !(cfg_ok_port || cfg_ok_vlan || cfg_ok_dyn); // [RQ11]
          end
          if (CFG_WE && cfg_ok_port) begin
            en_q[CFG_PORT]    <= CFG_WDATA[`PC_EN];  // [RQ23]
            ifilt_q[CFG_PORT] <= CFG_WDATA[`PC_IFILT];
            acc_q[CFG_PORT]   <= CFG_WDATA[`PC_ACC_LO +: 2];
            bpdu_q[CFG_PORT]  <= CFG_WDATA[`PC_BPDU_LO +: 2];
            pvid_q[CFG_PORT]  <= wpvid;
          end
        end
        default: begin
          state_q <= ST_INIT;
        end
      endcase
    end
  end

  // ==========================================================
  // stage 0: classify and look the VLAN up
  wire              in_tagged = (IN_ETYPE == `TPID);
  wire [`VIDW-1:0]  in_vid    = IN_TCI[`TCI_VID_HI:0];
  wire              in_prio   = in_tagged && (in_vid == `VID_PRIO);
  // priority-only frames take the port VID
  wire [`VIDW-1:0]  res_vid   = (in_tagged && !in_prio) ? in_vid : pvid_q[IN_PORT]; // [RQ10][RQ13]
  wire [2:0]        res_pri   = in_tagged ? IN_TCI[`TCI_PRI_HI:`TCI_PRI_LO] : 3'h0; // [RQ7]

  reg               s1_valid_q;
  reg [`PW-1:0]     s1_port_q;
  reg               s1_tagged_q;
  reg               s1_vidtag_q;
  reg               s1_cfi_q;
  reg [`VIDW-1:0]   s1_vid_q;
  reg [2:0]         s1_pri_q;
  reg [10:0]        s1_len_q;
  reg               s1_bpdu_q;
  reg [`NPORTS-1:0] s1_dmask_q;
  reg [31:0]        s1_vw_q;
  reg [`NPORTS-1:0] s1_dyn_q;

  wire              fifo_in_ready;
  wire              s1_push;
  wire              s1_drop;
  wire              s1_adv = !s1_valid_q || s1_drop || fifo_in_ready;
  wire              take   = IN_VALID && IN_READY;

  assign IN_READY = running && s1_adv;

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      s1_valid_q <= 1'b0;
    end else if (s1_adv) begin
      s1_valid_q <= take;
      if (take) begin
        s1_port_q   <= IN_PORT;
        s1_tagged_q <= in_tagged;
        s1_vidtag_q <= in_tagged && !in_prio;
        s1_cfi_q    <= in_tagged && IN_TCI[`TCI_CFI];
        s1_vid_q    <= res_vid;
        s1_pri_q    <= res_pri;
        // length in untagged form; tagged egress ports add the tag back
        s1_len_q    <= in_tagged ? (IN_LEN - `TAG_BYTES) : IN_LEN;  // [RQ6]
        s1_bpdu_q   <= IN_BPDU;
        s1_dmask_q  <= IN_DMASK;
        s1_vw_q     <= vlan_mem[res_vid];
        s1_dyn_q    <= dyn_mem[res_vid];
      end
    end
  end

  // ==========================================================
  // stage 1: decide
  reg               local_w;
  reg               fwd_w;
  reg               drop_w;
  reg [`NPORTS-1:0] dest_w;
  reg [`NPORTS-1:0] tagm_w;
  wire [`NPORTS-1:0] mem_w   = members(s1_vw_q, s1_dyn_q);
  wire [`NPORTS-1:0] tagcfg  = s1_vw_q[`VW_TAG_LO +: `NPORTS];
  wire [`NPORTS-1:0] in_bit  = {{(`NPORTS-1){1'b0}}, 1'b1} << s1_port_q;

  always @* begin
    local_w = 1'b0;
    fwd_w   = 1'b1;
    drop_w  = 1'b0;
    if (s1_bpdu_q) begin
      fwd_w   = 1'b0;
      local_w = 1'b1;
      if (BPDU_TRANSP_EN) begin                      // [RQ1]
        case (bpdu_q[s1_port_q])
          `BPDU_PEER:    local_w = 1'b1;             // [RQ2]
          `BPDU_TUNNEL: begin
            local_w = 1'b0;                          // [RQ3]
            fwd_w   = 1'b1;
          end
          `BPDU_DISCARD: begin
            local_w = 1'b0;                          // [RQ4]
            drop_w  = 1'b1;
          end
          default: begin
            local_w = !s1_tagged_q;                  // [RQ5]
            fwd_w   = s1_tagged_q;
          end
        endcase
      end
    end
    // forwarding destinations settle before any tag change is chosen
    dest_w = s1_dmask_q & mem_w & ~in_bit;           // [RQ15][RQ12]
    // CFI-set frames are kept off untagged ports rather than altered
    if (s1_cfi_q) begin
      dest_w = dest_w & tagcfg;                      // [RQ9]
    end
    tagm_w = dest_w & tagcfg;                        // [RQ18][RQ19]
    if (!en_q[s1_port_q]) begin
      drop_w = 1'b1;                                 // [RQ22]
    end
    if (!s1_bpdu_q || fwd_w) begin
      if ((acc_q[s1_port_q] == `ACC_TAGGED) && !s1_vidtag_q) begin
        drop_w = 1'b1;                               // [RQ20]
      end
      if ((acc_q[s1_port_q] == `ACC_UNTAGGED) && s1_vidtag_q) begin
        drop_w = 1'b1;                               // [RQ20]
      end
      if (ifilt_q[s1_port_q] && !mem_w[s1_port_q]) begin
        drop_w = 1'b1;                               // [RQ21]
      end
    end
    if (fwd_w && (dest_w == {`NPORTS{1'b0}})) begin
      drop_w = 1'b1;                                 // [RQ24]
    end
    if (!fwd_w) begin
      dest_w = {`NPORTS{1'b0}};
      tagm_w = {`NPORTS{1'b0}};
    end
  end

  assign s1_drop = s1_valid_q && drop_w;
  assign s1_push = s1_valid_q && !drop_w;

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      DROP_CNT <= 16'h0000;
    end else if (s1_drop) begin
      DROP_CNT <= DROP_CNT + 16'h0001;
    end
  end

  // ==========================================================
  // egress descriptor queue
  wire [`FIFO_WIDTH-1:0] fifo_in;
  wire [`FIFO_WIDTH-1:0] fifo_out;

  // generated tags always carry CFI zero
  assign fifo_in = {local_w, s1_len_q, s1_pri_q, 1'b0, s1_vid_q, tagm_w, dest_w}; // [RQ8]

  vlan_desc_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_vlan_desc_fifo (
    .clk       (CLK_SYS),
    .srst      (SRST),
    .in_valid  (s1_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (fifo_out)
  );

  assign OUT_DMASK   = fifo_out[7:0];
  assign OUT_TAGMASK = fifo_out[15:8];
  assign OUT_TCI     = fifo_out[31:16];
  assign OUT_LEN     = fifo_out[42:32];
  assign OUT_LOCAL   = fifo_out[43];
endmodule

// ==== vlan_consts.vh ====
`ifndef VLAN_CONSTS_VH
`define VLAN_CONSTS_VH

// ==========================================================
// sizes
`define NPORTS       8
`define PW           3
`define VIDW         12
`define NVLAN        4096
`define FIFO_WIDTH   44
`define FIFO_DEPTH   16
`define FIFO_AW      4

// ==========================================================
// tag layout
`define TPID         16'h8100
`define TAG_BYTES    11'h004
`define TCI_PRI_HI   15
`define TCI_PRI_LO   13
`define TCI_CFI      12
`define TCI_VID_HI   11
`define VID_PRIO     12'h000
`define VID_RSVD     12'hFFF
`define PVID_RST     12'h001

// ==========================================================
// per-port modes
`define BPDU_PEER    2'h0
`define BPDU_TUNNEL  2'h1
`define BPDU_DISCARD 2'h2
`define BPDU_NETWORK 2'h3
`define ACC_ALL      2'h0
`define ACC_TAGGED   2'h1
`define ACC_UNTAGGED 2'h2
`define REG_NORMAL   2'h0
`define REG_FIXED    2'h1
`define REG_FORBID   2'h2

// ==========================================================
// configuration write select and field positions
`define CFG_SEL_PORT 2'h0
`define CFG_SEL_VLAN 2'h1
`define CFG_SEL_DYN  2'h2
`define PC_EN        0
`define PC_IFILT     1
`define PC_ACC_LO    2
`define PC_BPDU_LO   4
`define PC_PVID_LO   6
`define VW_TAG_LO    16
`define VW_RST_DEF   32'h00005555
`define VW_RST_OTHER 32'h00000000

`endif

// ==== vlan_port_properties.sv ====
`timescale 1ns/1ps
// ==========================================
// egress descriptor and config properties
module vlan_port_checker (
  input logic        CLK_SYS,
  input logic        SRST,
  input logic        CFG_WE,
  input logic [1:0]  CFG_SEL,
  input logic [11:0] CFG_VID,
  input logic        CFG_ERR,
  input logic        INIT_DONE,
  input logic        IN_READY,
  input logic        OUT_VALID,
  input logic        OUT_READY,
  input logic [7:0]  OUT_DMASK,
  input logic [15:0] OUT_TCI,
  input logic        OUT_LOCAL,
  input logic [15:0] DROP_CNT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  AST_CFI_ZERO: assert property (OUT_VALID |-> !OUT_TCI[12])
    else $error("generated tag carries CFI set");
  AST_LOCAL_ONLY: assert property (OUT_VALID && OUT_LOCAL |-> OUT_DMASK == 8'h00)
    else $error("local descriptor also forwarded");
  AST_NO_EMPTY: assert property (OUT_VALID && !OUT_LOCAL |-> OUT_DMASK != 8'h00)
    else $error("forwarded descriptor with no ports");
  AST_VID_LEGAL: assert property (OUT_VALID && !OUT_LOCAL |->
    OUT_TCI[11:0] != 12'h000 && OUT_TCI[11:0] != 12'hFFF)
    else $error("forwarded with null or reserved vid");
  AST_HOLD: assert property (OUT_VALID && !OUT_READY |=>
    OUT_VALID && $stable(OUT_DMASK) && $stable(OUT_TCI))
    else $error("egress descriptor changed while stalled");
  AST_RSVD_REFUSED: assert property (CFG_WE && INIT_DONE && CFG_SEL != 2'h0 &&
    (CFG_VID == 12'hFFF || CFG_VID == 12'h000) |=> CFG_ERR)
    else $error("write to reserved vlan not refused");
  AST_ERR_CAUSE: assert property (CFG_ERR |-> $past(CFG_WE) && $past(INIT_DONE))
    else $error("refusal without a write");
  AST_DROP_STEP: assert property (DROP_CNT != $past(DROP_CNT) |->
    DROP_CNT == $past(DROP_CNT) + 16'h0001)
    else $error("drop count jumped");
  AST_SWEEP: assert property ($fell(SRST) |-> (!INIT_DONE && !IN_READY) [*8])
    else $error("ready before table sweep");
endmodule

// ==== peer_port_sink.sv ====
`timescale 1ns/1ps
// ==========================================
// egress peer: takes descriptors, may stall
module peer_port_sink (
  input  logic        clk,
  input  logic        srst,
  input  logic        stall,
  input  logic        valid,
  output logic        ready,
  input  logic [43:0] desc
);
  logic [43:0] q[$];
  initial ready = 1'b0;
  // ready moves off the sampling edge only
  always @(negedge clk) ready <= !srst && !stall;
  always @(posedge clk) if (valid && ready) q.push_back(desc);
endmodule

// ==== vlan_tag_port_processor_tb_top.sv ====
`timescale 1ns/1ps
`include "vlan_consts.vh"
module vlan_tag_port_processor_tb_top;
  localparam logic [43:0] ALL = 44'hFFFFFFFFFFF;
  localparam logic [43:0] LOC = 44'h800000000FF;
  localparam logic [43:0] LENM = 44'h7FF00000000;
  logic        clk = 1'b0, srst = 1'b1, transp = 1'b0, cfg_we = 1'b0, stall = 1'b0;
  logic [1:0]  cfg_sel = 2'h0;
  logic [2:0]  cfg_port = 3'h0, in_port = 3'h0;
  logic [11:0] cfg_vid = 12'h000;
  logic [31:0] cfg_wdata = 32'h00000000;
  logic        in_valid = 1'b0, in_bpdu = 1'b0;
  logic [15:0] in_etype = 16'h0800, in_tci = 16'h0000;
  logic [10:0] in_len = 11'h040;
  logic [7:0]  in_dmask = 8'hFF;
  logic        cfg_err, init_done, in_ready, out_valid, out_ready, out_local;
  logic [7:0]  out_dmask, out_tagmask;
  logic [15:0] out_tci, drop_cnt;
  logic [10:0] out_len;
  int          error_cnt = 0, comparisons = 0, cycles = 0, n;

  always #4 clk = ~clk;

  vlan_tag_port_processor u_vlan_tag_port_processor (
    .CLK_SYS(clk), .SRST(srst), .BPDU_TRANSP_EN(transp), .CFG_WE(cfg_we), .CFG_SEL(cfg_sel),
    .CFG_PORT(cfg_port), .CFG_VID(cfg_vid), .CFG_WDATA(cfg_wdata), .CFG_ERR(cfg_err),
    .INIT_DONE(init_done), .IN_VALID(in_valid), .IN_READY(in_ready), .IN_PORT(in_port),
    .IN_ETYPE(in_etype), .IN_TCI(in_tci), .IN_LEN(in_len), .IN_BPDU(in_bpdu),
    .IN_DMASK(in_dmask), .OUT_VALID(out_valid), .OUT_READY(out_ready),
    .OUT_DMASK(out_dmask), .OUT_TAGMASK(out_tagmask), .OUT_TCI(out_tci), .OUT_LEN(out_len),
    .OUT_LOCAL(out_local), .DROP_CNT(drop_cnt));

  peer_port_sink u_peer_port_sink (
    .clk(clk), .srst(srst), .stall(stall), .valid(out_valid), .ready(out_ready),
    .desc({out_local, out_len, out_tci, out_tagmask, out_dmask}));

  // ==========================================
  // shared tasks
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [43:0] dsc(logic [15:0] tci, logic [7:0] tg, logic [7:0] dm);
    return {1'b0, 11'h040, tci, tg, dm};
  endfunction

  // port index rides in the low vid bits for port writes
  task automatic cfg(input logic [1:0] sel, input logic [11:0] vid, input logic [31:0] wd,
                     input logic err);
    @(negedge clk);
    {cfg_we, cfg_sel, cfg_port, cfg_vid, cfg_wdata} = {1'b1, sel, vid[2:0], vid, wd};
    @(negedge clk);
    cfg_we = 1'b0;
    check(cfg_err, err);
  endtask

  task automatic frame(input logic [2:0] port, input logic [15:0] tci, input logic tg, bp,
                       input logic [43:0] exp, msk, input logic drop);
    logic [15:0] base;
    int k;
    base = drop_cnt;
    @(negedge clk);
    {in_valid, in_port, in_tci, in_bpdu} = {1'b1, port, tci, bp};
    {in_etype, in_len} = {tg ? `TPID : 16'h0800, tg ? 11'h044 : 11'h040};
    #1;
    for (k = 0; k < 50 && !in_ready; k++) begin
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    in_valid = 1'b0;
    if (drop) begin
      repeat (4) @(negedge clk);
      check(drop_cnt, base + 16'h0001);
      check(u_peer_port_sink.q.size(), 0);
    end else begin
      for (k = 0; k < 40 && u_peer_port_sink.q.size() == 0; k++) @(negedge clk);
      check(drop_cnt, base);
      if (u_peer_port_sink.q.size() == 0) check(1'b0, 1'b1);
      else check(u_peer_port_sink.q.pop_front() & msk, exp);
    end
  endtask

  // ==========================================
  // scenarios
  task automatic t_defaults();
    frame(3'h0, 16'h0000, 0, 0, dsc(16'h0001, 8'h00, 8'hFE), ALL, 0);
    frame(3'h3, 16'hA001, 1, 0, dsc(16'hA001, 8'h00, 8'hF7), ALL, 0);
    frame(3'h5, 16'h6000, 1, 0, dsc(16'h6001, 8'h00, 8'hDF), ALL, 0);
    frame(3'h2, 16'hB001, 1, 0, 44'h0, 44'h0, 1);
  endtask

  task automatic t_vlan();
    cfg(2'h1, 12'h005, 32'h00020025, 0);
    cfg(2'h2, 12'h005, 32'h0000000C, 0);
    frame(3'h0, 16'h0005, 1, 0, dsc(16'h0005, 8'h02, 8'h0A), ALL, 0);
    frame(3'h0, 16'h1005, 1, 0, dsc(16'h0005, 8'h02, 8'h02), ALL, 0);
    cfg(2'h0, 12'h003, 32'h00000141, 0);
    frame(3'h3, 16'h0000, 0, 0, dsc(16'h0005, 8'h02, 8'h03), ALL, 0);
    cfg(2'h1, 12'hFFF, 32'h00000001, 1);
    cfg(2'h2, 12'h000, 32'h000000FF, 1);
    cfg(2'h3, 12'h005, 32'h00000000, 1);
    cfg(2'h0, 12'h004, 32'h00000001, 1);
    cfg(2'h0, 12'h004, 32'h0003FFC1, 1);
    frame(3'h0, 16'h0FFF, 1, 0, 44'h0, 44'h0, 1);
    cfg(2'h2, 12'h006, 32'h00000003, 0);
    frame(3'h0, 16'h0006, 1, 0, dsc(16'h0006, 8'h00, 8'h02), ALL, 0);
    cfg(2'h2, 12'h006, 32'h00000001, 0);
    frame(3'h0, 16'h0006, 1, 0, 44'h0, 44'h0, 1);
  endtask

  task automatic pf(input logic [31:0] wd, input logic [15:0] tci, input logic tg, drop);
    cfg(2'h0, 12'h004, wd, 0);
    frame(3'h4, tci, tg, 0, dsc(16'h0001, 8'h00, 8'hEF), ALL, drop);
  endtask

  task automatic t_filters();
    pf(32'h00000045, 16'h0000, 0, 1);
    pf(32'h00000045, 16'h0001, 1, 0);
    pf(32'h00000049, 16'h0001, 1, 1);
    pf(32'h00000049, 16'h0000, 0, 0);
    pf(32'h00000043, 16'h0005, 1, 1);
    pf(32'h00000043, 16'h0001, 1, 0);
    pf(32'h00000040, 16'h0000, 0, 1);
  endtask

  // kind: 0 local, 1 forwarded, 2 dropped
  task automatic bp(input logic tr, input logic [31:0] wd, input logic tg, input int kind);
    transp = tr;
    cfg(2'h0, 12'h005, wd, 0);
    frame(3'h5, tg ? 16'h0001 : 16'h0000, tg, 1, kind == 0 ? 44'h80000000000 :
          dsc(16'h0001, 8'h00, 8'hDF), kind == 0 ? LOC : ALL, kind == 2);
  endtask

  task automatic t_bpdu();
    bp(0, 32'h00000061, 0, 0);
    bp(1, 32'h00000041, 0, 0);
    bp(1, 32'h00000051, 0, 1);
    bp(1, 32'h00000061, 0, 2);
    bp(1, 32'h00000071, 0, 0);
    bp(1, 32'h00000071, 1, 1);
  endtask

  // stage register plus 16 buffer words fill before refusal
  task automatic t_fifo();
    int took;
    took = 0;
    stall = 1'b1;
    @(negedge clk);
    for (n = 0; n < 24; n++) begin
      {in_valid, in_port, in_tci, in_bpdu} = {1'b1, 3'h0, 16'h0000, 1'b0};
      {in_etype, in_len} = {16'h0800, 11'h040 + took[10:0]};
      #1;
      if (in_ready) took++;
      @(negedge clk);
    end
    in_valid = 1'b0;
    check(took, 17);
    stall = 1'b0;
    for (n = 0; n < 17; n++) begin
      for (int k = 0; k < 40 && u_peer_port_sink.q.size() == 0; k++) @(negedge clk);
      check(u_peer_port_sink.q.pop_front() & LENM, {1'b0, 11'h040 + n[10:0], 32'h0});
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (n = 0; n < 5000 && !init_done; n++) @(negedge clk);
    check(init_done, 1'b1);
    t_defaults();
    t_vlan();
    t_filters();
    t_bpdu();
    t_fifo();
    wrap_up();
  end
endmodule

bind vlan_tag_port_processor vlan_port_checker u_vlan_port_checker (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .CFG_WE(CFG_WE), .CFG_SEL(CFG_SEL), .CFG_VID(CFG_VID),
  .CFG_ERR(CFG_ERR), .INIT_DONE(INIT_DONE), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID),
  .OUT_READY(OUT_READY), .OUT_DMASK(OUT_DMASK), .OUT_TCI(OUT_TCI), .OUT_LOCAL(OUT_LOCAL),
  .DROP_CNT(DROP_CNT));
